// >>> core/licd_pkg.sv
// shared constants and carrier types for the indirect command decoder
`default_nettype none
package licd_pkg;
	// command bytes
	localparam logic [7:0] CMD_CURSOR_SHAPE = 8'h5D;
	localparam logic [5:0] CMD_CURSOR_DIR_TOP = 6'h13;
	localparam logic [7:0] CMD_LAYER_OVERLAY = 8'h5B;
	localparam logic [7:0] CMD_GLYPH_BASE = 8'h5C;
	localparam logic [7:0] CMD_PIXEL_HSCROLL = 8'h5A;
	localparam logic [7:0] CMD_CURSOR_WRITE = 8'h46;
	localparam logic [7:0] CMD_CURSOR_READ = 8'h47;
	localparam logic [7:0] CMD_DEPTH = 8'h60;
	// field positions
	localparam int SIZE_LSB = 0;
	localparam int MODE_BIT = 7;
	localparam int OV_BIT = 4;
	localparam int DM3_BIT = 3;
	localparam int DM1_BIT = 2;
	localparam int MIX_LSB = 0;
	localparam int DIR_LSB = 0;
	localparam int HSCR_LSB = 0;
	localparam int DEPTH_LSB = 0;
	localparam int BYTE_W = 8;
	// move direction codes
	localparam logic [1:0] DIR_RIGHT = 2'h0;
	localparam logic [1:0] DIR_LEFT = 2'h1;
	localparam logic [1:0] DIR_UP = 2'h2;
	localparam logic [1:0] DIR_DOWN = 2'h3;
	// glyph layout
	localparam logic [3:0] ONE_BYTE_MAX_COL = 4'h7;
	// reset values
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [3:0] SIZE_RST = 4'h0;
	localparam logic [1:0] CODE2_RST = 2'h0;
	localparam logic [2:0] HSCR_RST = 3'h0;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_SHAPE,
		SEQ_OVERLAY,
		SEQ_GLYPH,
		SEQ_HSCROLL,
		SEQ_CWRITE,
		SEQ_CREAD,
		SEQ_DEPTH
	} licd_seq_t;

	typedef struct packed {
		logic [3:0] cursor_hsize;
		logic [3:0] cursor_vsize;
		logic cursor_mode_bit;
		logic [1:0] move_dir;
		logic three_layer_select;
		logic block3_display_mode;
		logic block1_display_mode;
		logic [1:0] layer_combine;
		logic [15:0] glyph_base;
		logic [2:0] pixel_hscroll;
		logic [1:0] depth_sel;
	} licd_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic cmd_param_select;
		logic [7:0] data;
	} licd_host_t;
endpackage
`default_nettype wire

// >>> core/licd_cursor.sv
// cursor address register with byte loads and auto move on memory access
`timescale 1ns/1ps
`default_nettype none
module licd_cursor #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// byte loads
	input wire logic load_low,
	input wire logic load_high,
	input wire logic [7:0] load_data,
	// movement
	input wire logic step,
	input wire logic [1:0] move_dir,
	input wire logic [ADDR_W-1:0] addr_pitch,
	// current address
	output logic [ADDR_W-1:0] cursor_addr
);
	logic [ADDR_W-1:0] next_cursor_addr;

	// byte loads split the address at bit 8, so widths outside 9 to 16 cannot be served
	if (ADDR_W < 9 || ADDR_W > 16)
	begin : g_bad_width
		$error("licd_cursor: ADDR_W must be 9 to 16");
	end

	// loads take priority so a host write is never undone by a same-cycle step
	always_comb
	begin
		next_cursor_addr = cursor_addr;
		if (load_low)
			next_cursor_addr[7:0] = load_data;
		else if (load_high)
			next_cursor_addr[ADDR_W-1:8] = load_data[ADDR_W-9:0];
		else if (step)
		begin
			// [RL18] step by direction
			case (move_dir)
				licd_pkg::DIR_RIGHT: next_cursor_addr = cursor_addr + ADDR_W'(1);
				licd_pkg::DIR_LEFT: next_cursor_addr = cursor_addr - ADDR_W'(1);
				licd_pkg::DIR_UP: next_cursor_addr = cursor_addr - addr_pitch;
				licd_pkg::DIR_DOWN: next_cursor_addr = cursor_addr + addr_pitch;
				default: next_cursor_addr = cursor_addr;
			endcase
		end
	end

	// address register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cursor_addr <= ADDR_W'(licd_pkg::ADDR_RST);
		else
			cursor_addr <= next_cursor_addr;
	end
endmodule // licd_cursor
`default_nettype wire

// >>> core/licd_glyph.sv
// glyph bitmap pixel picker for character fields up to 16 pixels wide
`timescale 1ns/1ps
`default_nettype none
module licd_glyph (
	// field setup
	input wire logic [3:0] char_field_width,
	input wire logic [3:0] pixel_col,
	// bitmap row, first byte is leftmost
	input wire logic [7:0] glyph_byte0,
	input wire logic [7:0] glyph_byte1,
	// results
	output logic two_bytes,
	output logic pixel
);
	// [RL15] two bytes past 8
	assign two_bytes = (char_field_width > licd_pkg::ONE_BYTE_MAX_COL);

	// no spacing is inserted: bits of the bitmap past the glyph show as they are,
	// so blank margins come only from zeros the host stores there
	always_comb
	begin
		pixel = 1'b0;
		if (pixel_col <= char_field_width)
		begin
			// [RL13] msb is leftmost pixel
			if (pixel_col[3])
				pixel = glyph_byte1[3'h7 - pixel_col[2:0]];
			else
				pixel = glyph_byte0[3'h7 - pixel_col[2:0]];
		end
	end
endmodule // licd_glyph
`default_nettype wire

// >>> core/licd_decoder.sv
// indirect command byte decoder with parameter routing and cursor readback
//
// Operation
// [RL1] host sends block4 start only dual two-layer
// [RL2] 5Dh is cursor shape, P1 width
// [RL3] shape P2: bit7 mode, bits3-0 height
// [RL4] 010011xx sets move direction, no parameters
// [RL5] 5Bh overlay P1 bit4 three-layer select
// [RL6] overlay bits3-2 block3/block1 display modes
// [RL7] overlay bits1-0 layer combine method
// [RL8] 5Ch glyph base, low then high
// [RL9] 5Ah one parameter, bits2-0 pixel scroll
// [RL10] 46h loads cursor, low then high
// [RL11] 47h: next two reads give cursor
// [RL12] 60h parameter bits1-0 select depth
// [RL13] bitmap origin top left, bits horizontal
// [RL14] wider field blank only if bitmap zero
// [RL15] field width to 16, two bytes
// [RL16] no spacing; wide pitch needs two bytes
// [RL17] select high command, low parameter
// [RL18] memory access moves cursor by direction
// [RL19] count parameters; new command restarts
//
// Limitations
// - strobes are taken as one clock wide; a strobe held high acts on every cycle
// - a cursor byte load in the same cycle as a memory access wins and the step is lost
// - each readback byte shows the cursor as it stands at that read
// - parameter bits outside the documented fields are dropped, not checked
// - pixel columns past the field width read blank in the pixel pick
`timescale 1ns/1ps
`default_nettype none
module licd_decoder #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host bus, one-cycle strobes
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic cmd_param_select,
	input wire logic [7:0] host_din,
	output logic [7:0] host_dout,
	output logic host_dout_valid,
	// display memory side
	input wire logic mem_access,
	input wire logic [ADDR_W-1:0] addr_pitch,
	output logic [ADDR_W-1:0] cursor_addr,
	// decoded settings
	output var licd_pkg::licd_cfg_t cfg,
	// glyph scan
	input wire logic [3:0] char_field_width,
	input wire logic [3:0] pixel_col,
	input wire logic [7:0] glyph_byte0,
	input wire logic [7:0] glyph_byte1,
	output logic glyph_two_bytes,
	output logic glyph_pixel
);
	// readback and byte loads split the cursor into two fixed bytes, so only 16 bits are served
	if (ADDR_W != 16)
	begin : g_bad_width
		$error("licd_decoder: ADDR_W must be 16");
	end

	licd_pkg::licd_host_t host;
	licd_pkg::licd_seq_t seq, next_seq;
	logic pidx, next_pidx;
	licd_pkg::licd_cfg_t next_cfg;
	logic [7:0] next_host_dout;
	logic next_host_dout_valid;
	logic cmd_wr, par_wr, data_rd;
	logic load_low, load_high;
	logic two_bytes_c, pixel_c;
	logic cread_hit;
	logic next_glyph_two_bytes, next_glyph_pixel;

	assign host = '{wr: host_wr, rd: host_rd, cmd_param_select: cmd_param_select, data: host_din};

	// [RL17] decode select line
	assign cmd_wr = host.wr && host.cmd_param_select;
	assign par_wr = host.wr && !host.cmd_param_select;
	assign data_rd = host.rd && host.cmd_param_select;

	// a read that belongs to a pending cursor readback
	assign cread_hit = data_rd && seq == licd_pkg::SEQ_CREAD;

	// sequence tracking: which command owns the next parameter, and its index
	always_comb
	begin
		next_seq = seq;
		next_pidx = pidx;
		// a command byte always wins, so the host can abort a half-sent sequence at any time
		if (cmd_wr)
		begin
			// [RL19] new command restarts count
			next_pidx = 1'b0;
			case (host.data)
				licd_pkg::CMD_CURSOR_SHAPE: next_seq = licd_pkg::SEQ_SHAPE;
				licd_pkg::CMD_LAYER_OVERLAY: next_seq = licd_pkg::SEQ_OVERLAY;
				licd_pkg::CMD_GLYPH_BASE: next_seq = licd_pkg::SEQ_GLYPH;
				licd_pkg::CMD_PIXEL_HSCROLL: next_seq = licd_pkg::SEQ_HSCROLL;
				licd_pkg::CMD_CURSOR_WRITE: next_seq = licd_pkg::SEQ_CWRITE;
				licd_pkg::CMD_CURSOR_READ: next_seq = licd_pkg::SEQ_CREAD;
				licd_pkg::CMD_DEPTH: next_seq = licd_pkg::SEQ_DEPTH;
				default: next_seq = licd_pkg::SEQ_IDLE;
			endcase
		end
		else if (par_wr)
		begin
			// parameters with no owning command fall to idle and are dropped
			// [RL19] route by count
			case (seq)
				licd_pkg::SEQ_SHAPE,
				licd_pkg::SEQ_GLYPH,
				licd_pkg::SEQ_CWRITE:
				begin
					next_pidx = 1'b1;
					if (pidx)
						next_seq = licd_pkg::SEQ_IDLE;
				end
				default: next_seq = licd_pkg::SEQ_IDLE;
			endcase
		end
		else if (cread_hit)
		begin
			// [RL11] two reads then done
			next_pidx = 1'b1;
			if (pidx)
				next_seq = licd_pkg::SEQ_IDLE;
		end
	end

	// sequence registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq <= licd_pkg::SEQ_IDLE;
			pidx <= 1'b0;
		end
		else
		begin
			seq <= next_seq;
			pidx <= next_pidx;
		end
	end

	// settings update from parameter bytes; unused bits are simply not stored
	always_comb
	begin
		next_cfg = cfg;
		if (cmd_wr && host.data[7:2] == licd_pkg::CMD_CURSOR_DIR_TOP)
			// [RL4] direction from command
			next_cfg.move_dir = host.data[licd_pkg::DIR_LSB +: 2];
		else if (par_wr)
		begin
			case (seq)
				licd_pkg::SEQ_SHAPE:
				begin
					if (!pidx)
						// [RL2] width in P1
						next_cfg.cursor_hsize = host.data[licd_pkg::SIZE_LSB +: 4];
					else
					begin
						// [RL3] mode and height
						next_cfg.cursor_mode_bit = host.data[licd_pkg::MODE_BIT];
						next_cfg.cursor_vsize = host.data[licd_pkg::SIZE_LSB +: 4];
					end
				end
				licd_pkg::SEQ_OVERLAY:
				begin
					// [RL5] three-layer select
					next_cfg.three_layer_select = host.data[licd_pkg::OV_BIT];
					// [RL6] block display modes
					next_cfg.block3_display_mode = host.data[licd_pkg::DM3_BIT];
					next_cfg.block1_display_mode = host.data[licd_pkg::DM1_BIT];
					// [RL7] layer combine code
					next_cfg.layer_combine = host.data[licd_pkg::MIX_LSB +: 2];
				end
				licd_pkg::SEQ_GLYPH:
				begin
					// [RL8] glyph base bytes
					if (!pidx)
						next_cfg.glyph_base[7:0] = host.data;
					else
						next_cfg.glyph_base[15:8] = host.data;
				end
				licd_pkg::SEQ_HSCROLL:
					// [RL9] pixel scroll
					next_cfg.pixel_hscroll = host.data[licd_pkg::HSCR_LSB +: 3];
				licd_pkg::SEQ_DEPTH:
					// [RL12] depth select
					next_cfg.depth_sel = host.data[licd_pkg::DEPTH_LSB +: 2];
				default: next_cfg = cfg;
			endcase
		end
	end

	// settings register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// all settings clear to zero; the host configures everything after reset
			cfg <= '{
				cursor_hsize: licd_pkg::SIZE_RST,
				cursor_vsize: licd_pkg::SIZE_RST,
				cursor_mode_bit: 1'b0,
				move_dir: licd_pkg::CODE2_RST,
				three_layer_select: 1'b0,
				block3_display_mode: 1'b0,
				block1_display_mode: 1'b0,
				layer_combine: licd_pkg::CODE2_RST,
				glyph_base: licd_pkg::ADDR_RST,
				pixel_hscroll: licd_pkg::HSCR_RST,
				depth_sel: licd_pkg::CODE2_RST
			};
		end
		else
			cfg <= next_cfg;
	end

	// [RL10] cursor byte loads
	assign load_low = par_wr && seq == licd_pkg::SEQ_CWRITE && !pidx;
	assign load_high = par_wr && seq == licd_pkg::SEQ_CWRITE && pidx;

	// cursor register sits apart so its step arithmetic stays in one place
	licd_cursor #(
		.ADDR_W(ADDR_W)
	) u_cursor (
		.clk(clk),
		.rst_n(rst_n),
		.load_low(load_low),
		.load_high(load_high),
		.load_data(host.data),
		.step(mem_access),
		.move_dir(cfg.move_dir),
		.addr_pitch(addr_pitch),
		.cursor_addr(cursor_addr)
	);

	// read data: low byte on the first read, high on the second
	always_comb
	begin
		next_host_dout = host_dout;
		next_host_dout_valid = 1'b0;
		// host_dout keeps its value after the pulse so a slow host can still fetch it
		if (cread_hit)
		begin
			// [RL11] low then high
			next_host_dout_valid = 1'b1;
			next_host_dout = pidx ? cursor_addr[15:8] : cursor_addr[7:0];
		end
	end

	// read register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_dout <= 8'h00;
			host_dout_valid <= 1'b0;
		end
		else
		begin
			host_dout <= next_host_dout;
			host_dout_valid <= next_host_dout_valid;
		end
	end

	// [RL14] bitmap shown unaltered
	licd_glyph u_glyph (
		.char_field_width(char_field_width),
		.pixel_col(pixel_col),
		.glyph_byte0(glyph_byte0),
		.glyph_byte1(glyph_byte1),
		.two_bytes(two_bytes_c),
		.pixel(pixel_c)
	);

	// glyph next values; the scan side has no handshake, so a fresh pick every cycle
	always_comb
	begin
		next_glyph_two_bytes = two_bytes_c;
		next_glyph_pixel = pixel_c;
	end

	// glyph results registered; one cycle of latency behind the scan inputs
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			glyph_two_bytes <= 1'b0;
			glyph_pixel <= 1'b0;
		end
		else
		begin
			// [RL16] two-byte fetch for wide pitch
			glyph_two_bytes <= next_glyph_two_bytes;
			glyph_pixel <= next_glyph_pixel;
		end
	end
endmodule // licd_decoder
`default_nettype wire

// >>> testbench/licd_host_model.sv
// host cpu model driving the indirect command bus
`timescale 1ns/1ps
`default_nettype none
module licd_host_model (
	// clock
	input wire logic clk,
	// host bus
	output logic host_wr,
	output logic host_rd,
	output logic cmd_param_select,
	output logic [7:0] host_din
);
	// bus starts quiet
	initial
	begin
		host_wr = 1'b0;
		host_rd = 1'b0;
		cmd_param_select = 1'b0;
		host_din = 8'hA5;
	end
	// select marks command; one transfer per clock
	task automatic xfer(input logic w, input logic r, input logic s, input logic [7:0] d);
		begin
			host_wr <= w;
			host_rd <= r;
			cmd_param_select <= s;
			host_din <= d;
			@(posedge clk);
		end
	endtask
	// released data turns over so stale bytes never look valid
	task automatic idle();
		begin
			host_wr <= 1'b0;
			host_rd <= 1'b0;
			host_din <= ~host_din;
			@(posedge clk);
		end
	endtask
endmodule // licd_host_model
`default_nettype wire

// >>> testbench/licd_decoder_monitor.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module licd_decoder_monitor #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// host bus
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic cmd_param_select,
	input wire logic [7:0] host_din,
	input wire logic [7:0] host_dout,
	input wire logic host_dout_valid,
	// memory side and settings
	input wire logic mem_access,
	input wire logic [ADDR_W-1:0] addr_pitch,
	input wire logic [ADDR_W-1:0] cursor_addr,
	input wire licd_pkg::licd_cfg_t cfg,
	// glyph scan
	input wire logic [3:0] char_field_width,
	input wire logic [3:0] pixel_col,
	input wire logic [7:0] glyph_byte0,
	input wire logic [7:0] glyph_byte1,
	input wire logic glyph_two_bytes,
	input wire logic glyph_pixel
);
	logic [ADDR_W-1:0] stepped;
	logic exp_pix;
	logic cmd_wr;
	logic par_wr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// write kinds seen on the bus
	assign cmd_wr = host_wr & cmd_param_select;
	assign par_wr = host_wr & ~cmd_param_select;
	// cursor after one move; pitch wraps in 16 bits
	always_comb
	begin
		case (cfg.move_dir)
			licd_pkg::DIR_RIGHT: stepped = cursor_addr + 1'b1;
			licd_pkg::DIR_LEFT: stepped = cursor_addr - 1'b1;
			licd_pkg::DIR_UP: stepped = cursor_addr - addr_pitch;
			default: stepped = cursor_addr + addr_pitch;
		endcase
	end
	// columns past the field read blank
	always_comb
	begin
		if (pixel_col > char_field_width) exp_pix = 1'b0;
		else if (pixel_col > 4'h7) exp_pix = glyph_byte1[3'h7 - pixel_col[2:0]];
		else exp_pix = glyph_byte0[3'h7 - pixel_col[2:0]];
	end
	a_valid_cause: assert property (
		host_dout_valid |-> $past(host_rd && cmd_param_select && !host_wr)) else $error("read data without read");
	a_dir_load: assert property (
		cmd_wr && host_din[7:2] == licd_pkg::CMD_CURSOR_DIR_TOP |=> cfg.move_dir == $past(host_din[1:0]))
		else $error("move direction not loaded");
	a_cursor_step: assert property (
		mem_access && !host_wr |=> cursor_addr == $past(stepped)) else $error("cursor step wrong");
	a_cursor_hold: assert property (
		!mem_access && !host_wr |=> $stable(cursor_addr)) else $error("cursor moved idle");
	a_overlay_fields: assert property (
		cmd_wr && host_din == licd_pkg::CMD_LAYER_OVERLAY ##1 par_wr |=> {cfg.three_layer_select,
		cfg.block3_display_mode, cfg.block1_display_mode, cfg.layer_combine} == $past(host_din[4:0]))
		else $error("overlay fields wrong");
	a_shape_second: assert property (
		cmd_wr && host_din == licd_pkg::CMD_CURSOR_SHAPE ##1 par_wr ##1 par_wr
		|=> {cfg.cursor_mode_bit, cfg.cursor_vsize} == $past({host_din[7], host_din[3:0]})) else $error("shape p2 wrong");
	a_hscroll_load: assert property (
		cmd_wr && host_din == licd_pkg::CMD_PIXEL_HSCROLL ##1 par_wr |=> cfg.pixel_hscroll == $past(host_din[2:0]))
		else $error("pixel scroll wrong");
	a_read_low: assert property (
		cmd_wr && host_din == licd_pkg::CMD_CURSOR_READ ##1 host_rd && cmd_param_select && !host_wr
		|=> host_dout_valid && host_dout == $past(cursor_addr[7:0])) else $error("cursor low read wrong");
	a_glyph_bytes: assert property (
		rst_n |=> glyph_two_bytes == ($past(char_field_width) > 4'h7)) else $error("byte count wrong");
	a_glyph_pixel: assert property (
		rst_n |=> glyph_pixel == $past(exp_pix)) else $error("pixel pick wrong");
endmodule // licd_decoder_monitor
bind licd_decoder licd_decoder_monitor #(.ADDR_W(ADDR_W)) mon (.clk(clk), .rst_n(rst_n), .host_wr(host_wr),
	.host_rd(host_rd), .cmd_param_select(cmd_param_select), .host_din(host_din), .host_dout(host_dout),
	.host_dout_valid(host_dout_valid), .mem_access(mem_access), .addr_pitch(addr_pitch),
	.cursor_addr(cursor_addr), .cfg(cfg), .char_field_width(char_field_width), .pixel_col(pixel_col),
	.glyph_byte0(glyph_byte0), .glyph_byte1(glyph_byte1), .glyph_two_bytes(glyph_two_bytes),
	.glyph_pixel(glyph_pixel));
`default_nettype wire

// >>> testbench/licd_decoder_bench.sv
// random command traffic against the decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin bad_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module licd_decoder_bench;
	logic clk;
	logic rst_n = 1'b0;
	logic host_wr, host_rd, cmd_param_select, host_dout_valid, glyph_two_bytes, glyph_pixel;
	logic [7:0] host_din, host_dout;
	logic mem_access = 1'b0;
	logic [15:0] addr_pitch = 16'h0000;
	logic [15:0] cursor_addr, exp_cur;
	licd_pkg::licd_cfg_t cfg, exp_cfg;
	logic [3:0] char_field_width = 4'h0;
	logic [3:0] pixel_col = 4'h0;
	logic [7:0] glyph_byte0 = 8'h00;
	logic [7:0] glyph_byte1 = 8'h00;
	logic [7:0] cmds [11] = '{8'h5D, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h5B, 8'h5C, 8'h5A, 8'h46, 8'h60, 8'h42};
	int seed = 74;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	licd_decoder dut (.clk(clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
		.cmd_param_select(cmd_param_select), .host_din(host_din), .host_dout(host_dout),
		.host_dout_valid(host_dout_valid), .mem_access(mem_access), .addr_pitch(addr_pitch),
		.cursor_addr(cursor_addr), .cfg(cfg), .char_field_width(char_field_width), .pixel_col(pixel_col),
		.glyph_byte0(glyph_byte0), .glyph_byte1(glyph_byte1), .glyph_two_bytes(glyph_two_bytes),
		.glyph_pixel(glyph_pixel));
	licd_host_model host (.clk(clk), .host_wr(host_wr), .host_rd(host_rd),
		.cmd_param_select(cmd_param_select), .host_din(host_din));
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		char_field_width <= $random(seed);
		pixel_col <= $random(seed);
		glyph_byte0 <= $random(seed);
		glyph_byte1 <= char_field_width[3] ? $random(seed) : 8'h00;
	end
	// hang guard, well above the expected run
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		begin
			if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask
	// expected effect of parameter i; surplus bytes change nothing
	function automatic void apply(input logic [7:0] c, input int i, input logic [7:0] p);
		case (c)
			licd_pkg::CMD_CURSOR_SHAPE: if (i == 0) exp_cfg.cursor_hsize = p[3:0];
				else if (i == 1) {exp_cfg.cursor_mode_bit, exp_cfg.cursor_vsize} = {p[7], p[3:0]};
			licd_pkg::CMD_LAYER_OVERLAY: if (i == 0) {exp_cfg.three_layer_select, exp_cfg.block3_display_mode,
				exp_cfg.block1_display_mode, exp_cfg.layer_combine} = p[4:0];
			licd_pkg::CMD_GLYPH_BASE: if (i < 2) exp_cfg.glyph_base[i*8 +: 8] = p;
			licd_pkg::CMD_PIXEL_HSCROLL: if (i == 0) exp_cfg.pixel_hscroll = p[2:0];
			licd_pkg::CMD_CURSOR_WRITE: if (i < 2) exp_cur[i*8 +: 8] = p;
			licd_pkg::CMD_DEPTH: if (i == 0) exp_cfg.depth_sel = p[1:0];
			default: ;
		endcase
	endfunction
	// command then n back-to-back parameters, random spare bits included
	task automatic send(input logic [7:0] c, input int n);
		logic [7:0] p;
		begin
			@(posedge clk);
			host.xfer(1'b1, 1'b0, 1'b1, c);
			if (c[7:2] == licd_pkg::CMD_CURSOR_DIR_TOP) exp_cfg.move_dir = c[1:0];
			for (int i = 0; i < n; i++)
			begin
				p = $random(seed);
				host.xfer(1'b1, 1'b0, 1'b0, p);
				apply(c, i, p);
			end
			host.idle();
			#1;
		end
	endtask
	// three reads plus a select-low read: only the first two answer
	task automatic read_cursor();
		begin
			@(posedge clk);
			host.xfer(1'b1, 1'b0, 1'b1, licd_pkg::CMD_CURSOR_READ);
			repeat (3) host.xfer(1'b0, 1'b1, 1'b1, 8'h00);
			host.xfer(1'b0, 1'b1, 1'b0, 8'h00);
			host.idle();
			#1;
			`CHK("cursor_high", exp_cur[15:8], host_dout)
		end
	endtask
	// memory accesses with a fresh pitch each time
	task automatic steps(input int n);
		logic [15:0] pt;
		begin
			repeat (n)
			begin
				pt = $random(seed);
				@(posedge clk);
				mem_access <= 1'b1;
				addr_pitch <= pt;
				@(posedge clk);
				mem_access <= 1'b0;
				case (exp_cfg.move_dir)
					licd_pkg::DIR_RIGHT: exp_cur = exp_cur + 16'h0001;
					licd_pkg::DIR_LEFT: exp_cur = exp_cur - 16'h0001;
					licd_pkg::DIR_UP: exp_cur = exp_cur - pt;
					default: exp_cur = exp_cur + pt;
				endcase
			end
			#1;
			`CHK("cursor_step", exp_cur, cursor_addr)
		end
	endtask
	// main sequence
	initial
	begin
		exp_cfg = '0;
		exp_cur = 16'h0000;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK("cfg_reset", exp_cfg, cfg)
		`CHK("valid_reset", 1'b0, host_dout_valid)
		repeat (300)
		begin
			send(cmds[{$random(seed)} % 11], {$random(seed)} % 4);
			`CHK("cfg", exp_cfg, cfg)
			`CHK("cursor_load", exp_cur, cursor_addr)
			steps(2);
			read_cursor();
		end
		give_verdict();
	end
endmodule // licd_decoder_bench
`default_nettype wire
